// [rtl/hfac_pkg.sv]
// Constants for the filter chain and AGC configuration block.
// Assumes one processing clock and an APB register port with 32-bit data.
package hfac_pkg;
   // ==================================================================
   // Register map (byte addresses)
   localparam logic [7:0]  FILTER_CHAIN_CONFIG_ADDR = 8'h00;
   localparam logic [7:0]  AGC_CONFIG_ONE_ADDR      = 8'h04;
   localparam logic [7:0]  CONFIG_STATUS_ADDR       = 8'h08;
   localparam int          ADDR_WIDTH               = 8;

   // ==================================================================
   // Reset values
   localparam logic [31:0] FILTER_CHAIN_RESET = 32'h0010_0001;
   localparam logic [31:0] AGC_CONFIG_RESET   = 32'h0000_0000;

   // ==================================================================
   // Writable bit masks; reserved bits read as zero
   localparam logic [31:0] FILTER_CHAIN_MASK = 32'h003F_FFFF;
   localparam logic [31:0] AGC_CONFIG_MASK   = 32'h3FFF_FFFF;

   // ==================================================================
   // Filter chain fields
   localparam int FILTER_SYNC_EN_POS   = 21;
   localparam int HALFBAND_BYPASS_POS  = 20;
   localparam int LAST_HALFBAND_POS    = 19;
   localparam int HALFBAND_FIRST_POS   = 15;
   localparam int HALFBAND_STAGES      = 5;
   localparam int FIR_DECIM_LSB        = 11;
   localparam int FIR_DECIM_WIDTH      = 4;
   localparam int FIR_DUAL_REAL_POS    = 10;
   localparam int FIR_SYM_PARITY_POS   = 9;
   localparam int FIR_ASYMMETRIC_POS   = 8;
   localparam int FIR_TAPS_LSB         = 0;
   localparam int FIR_TAPS_WIDTH       = 8;
   localparam logic [4:0] FIR_DECIM_ZERO_CODE_FACTOR = 5'h10;

   // ==================================================================
   // AGC configuration fields
   localparam int AGC_SYNC_LOAD_POS    = 29;
   localparam int AGC_THRESHOLD_LSB    = 16;
   localparam int AGC_THRESHOLD_WIDTH  = 13;
   localparam int LOOP1_MANTISSA_LSB   = 12;
   localparam int LOOP1_EXPONENT_LSB   = 8;
   localparam int LOOP0_MANTISSA_LSB   = 4;
   localparam int LOOP0_EXPONENT_LSB   = 0;
   localparam int GAIN_FIELD_WIDTH     = 4;
   localparam logic [4:0] EXPONENT_BASE = 5'h0F;

   // ==================================================================
   // AGC arithmetic widths
   localparam int GAIN_ERROR_WIDTH     = 14;
   localparam int GAIN_STEP_WIDTH      = 18;
endpackage

// [rtl/hfac_config.sv]
// Configuration registers and decode for the halfband cascade, FIR and AGC loop.
// Assumes an APB master on pclk and that the sync, gain-select, magnitude
// and sample strobe inputs are already synchronous to pclk.
`timescale 1ns/10ps

module hfac_config
(
   input  wire logic                                     pclk,
   input  wire logic                                     presetn,
   input  wire logic                                     psel,
   input  wire logic                                     penable,
   input  wire logic                                     pwrite,
   input  wire logic [hfac_pkg::ADDR_WIDTH-1:0]          paddr,
   input  wire logic [31:0]                              pwdata,
   input  wire logic [3:0]                               pstrb,
   output logic      [31:0]                              prdata,
   output logic                                          pready,
   output logic                                          pslverr,
   input  wire logic                                     filter_align_sync_in,
   input  wire logic                                     agc_gain_select_in,
   input  wire logic                                     agc_sample_valid,
   input  wire logic [hfac_pkg::AGC_THRESHOLD_WIDTH-1:0] agc_magnitude,
   output logic      [hfac_pkg::HALFBAND_STAGES-1:0]     halfband_stage_enable,
   output logic                                          halfband_bypass,
   output logic      [4:0]                               fir_decimation,
   output logic                                          fir_dual_real,
   output logic                                          fir_symmetry_parity,
   output logic                                          fir_asymmetric,
   output logic      [hfac_pkg::FIR_TAPS_WIDTH-1:0]      fir_tap_count,
   output logic                                          config_invalid,
   output logic                                          filter_sequence_reset,
   output logic                                          agc_accumulator_load,
   output logic signed [hfac_pkg::GAIN_ERROR_WIDTH-1:0]  agc_gain_error,
   output logic signed [hfac_pkg::GAIN_STEP_WIDTH-1:0]   agc_gain_step,
   output logic                                          agc_step_valid
);
   import hfac_pkg::*;

   // ==================================================================
   // Functions

   // Address decode, shared by the write and the read path
   function automatic logic [2:0] reg_select(input logic [ADDR_WIDTH-1:0] addr);
      logic [2:0] sel;
      sel = 3'h0;
      if (addr == FILTER_CHAIN_CONFIG_ADDR)
      begin
         sel[0] = 1'b1;
      end
      if (addr == AGC_CONFIG_ONE_ADDR)
      begin
         sel[1] = 1'b1;
      end
      if (addr == CONFIG_STATUS_ADDR)
      begin
         sel[2] = 1'b1;
      end
      return sel;
   endfunction

   // Byte-lane merge of a write, with reserved bits forced low
   function automatic logic [31:0] merge_write(input logic [31:0] old_value,
                                               input logic [31:0] new_value,
                                               input logic [3:0]  strobe,
                                               input logic [31:0] mask);
      logic [31:0] result;
      result = old_value;
      for (int b = 0; b < 4; b++)
      begin
         if (strobe[b])
         begin
            result[b*8 +: 8] = new_value[b*8 +: 8];
         end
      end
      return result & mask;
   endfunction

   // ==================================================================
   // Registers and internal signals
   logic [31:0]                  filter_chain_config;
   logic [31:0]                  agc_config_one;
   logic [2:0]                   access_select;
   logic                         write_access;
   logic                         sync_sampled;
   logic                         sync_seen;
   logic                         taps_invalid;
   logic                         cascade_invalid;
   logic [FIR_DECIM_WIDTH-1:0]   decim_code;
   logic [GAIN_FIELD_WIDTH-1:0]  loop_gain_mantissa;
   logic [GAIN_FIELD_WIDTH-1:0]  loop_gain_exponent;
   logic [4:0]                   gain_shift;
   logic signed [GAIN_ERROR_WIDTH-1:0] next_gain_error;
   logic signed [GAIN_STEP_WIDTH-1:0]  scaled_error;
   logic [31:0]                  status_word;

   // ==================================================================
   // APB slave

   // Zero wait states: read data is loaded in the setup cycle
   // so every transfer ends in one access cycle and never stalls
   assign access_select = reg_select(paddr);
   assign write_access  = psel & penable & pwrite;
   assign pready        = 1'b1;
   assign pslverr       = psel & penable & ~(|access_select);

   // Register writes happen only in the access phase
   // Reserved bits are masked off, so they always read back zero
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         filter_chain_config <= FILTER_CHAIN_RESET;
      end
      else if (write_access && access_select[0])
      begin
         filter_chain_config <= merge_write(filter_chain_config, pwdata, pstrb,
                                            FILTER_CHAIN_MASK);
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         agc_config_one <= AGC_CONFIG_RESET;
      end
      else if (write_access && access_select[1])
      begin
         agc_config_one <= merge_write(agc_config_one, pwdata, pstrb,
                                       AGC_CONFIG_MASK);
      end
   end

   // Status word: block's own state; bit 2 is cleared by a write with bit 2 set
   assign status_word = {29'h0, sync_seen, cascade_invalid, taps_invalid};

   // Read mux; unmapped addresses read zero
   // Loaded at setup, so prdata stands through the whole access phase
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h0000_0000;
      end
      else if (psel && !penable && !pwrite)
      begin
         unique case (1'b1)
            access_select[0]: prdata <= filter_chain_config;
            access_select[1]: prdata <= agc_config_one;
            access_select[2]: prdata <= status_word;
            default:          prdata <= 32'h0000_0000;
         endcase
      end
   end

   // ==================================================================
   // Filter chain decode

   // Stage enables, each held off while the whole cascade is bypassed
   // Keeps a stale stage bit from reaching the datapath under bypass
   genvar stage;
   generate
      for (stage = 0; stage < HALFBAND_STAGES; stage++)
      begin : g_stage
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               halfband_stage_enable[stage] <= 1'b0;
            end
            else
            begin
               halfband_stage_enable[stage] <= ~filter_chain_config[HALFBAND_BYPASS_POS]
                  & filter_chain_config[HALFBAND_FIRST_POS + stage];
            end
         end
      end
   endgenerate

   assign decim_code = filter_chain_config[FIR_DECIM_LSB +: FIR_DECIM_WIDTH];

   // Host programming faults, flagged rather than corrected
   // Trade-off: the datapath still runs on whatever was written
   assign taps_invalid    = (filter_chain_config[FIR_TAPS_LSB +: FIR_TAPS_WIDTH] == 8'h00);
   assign cascade_invalid = ~filter_chain_config[HALFBAND_BYPASS_POS]
      & ~(|filter_chain_config[HALFBAND_FIRST_POS +: HALFBAND_STAGES]);

   // Registered FIR and cascade controls
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         halfband_bypass     <= 1'b1;
         fir_decimation      <= FIR_DECIM_ZERO_CODE_FACTOR;
         fir_dual_real       <= 1'b0;
         fir_symmetry_parity <= 1'b0;
         fir_asymmetric      <= 1'b0;
         fir_tap_count       <= 8'h01;
         config_invalid      <= 1'b0;
      end
      else
      begin
         halfband_bypass     <= filter_chain_config[HALFBAND_BYPASS_POS];
         fir_decimation      <= (decim_code == 4'h0) ? FIR_DECIM_ZERO_CODE_FACTOR
                                                     : {1'b0, decim_code};
         fir_dual_real       <= filter_chain_config[FIR_DUAL_REAL_POS];
         fir_symmetry_parity <= filter_chain_config[FIR_SYM_PARITY_POS];
         fir_asymmetric      <= filter_chain_config[FIR_ASYMMETRIC_POS];
         fir_tap_count       <=
            filter_chain_config[FIR_TAPS_LSB +: FIR_TAPS_WIDTH];
         config_invalid      <= taps_invalid | cascade_invalid;
      end
   end

   // ==================================================================
   // Alignment sync

   // Two register stages on pclk; pulses follow two cycles after the pin
   // Pin is taken as synchronous; an async source needs its own synchroniser
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync_sampled <= 1'b0;
      end
      else
      begin
         sync_sampled <= filter_align_sync_in;
      end
   end

   // Gated by the enable bits; a level sync repeats the reset each cycle
   // Both pulses share one timing, so filters and AGC realign together
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         filter_sequence_reset <= 1'b0;
         agc_accumulator_load  <= 1'b0;
      end
      else
      begin
         filter_sequence_reset <= sync_sampled
            & filter_chain_config[FILTER_SYNC_EN_POS];
         agc_accumulator_load  <= sync_sampled
            & agc_config_one[AGC_SYNC_LOAD_POS];
      end
   end

   // Sticky sync flag, cleared by a write to status with bit 2 set; a new sync wins
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync_seen <= 1'b0;
      end
      else if (sync_sampled)
      begin
         sync_seen <= 1'b1;
      end
      else if (write_access && access_select[2] && pwdata[2])
      begin
         sync_seen <= 1'b0;
      end
   end

   // ==================================================================
   // AGC loop gain

   // Loop one or loop zero fields by the gain-select input
   always_comb
   begin
      if (agc_gain_select_in)
      begin
         loop_gain_mantissa =
            agc_config_one[LOOP1_MANTISSA_LSB +: GAIN_FIELD_WIDTH];
         loop_gain_exponent =
            agc_config_one[LOOP1_EXPONENT_LSB +: GAIN_FIELD_WIDTH];
      end
      else
      begin
         loop_gain_mantissa =
            agc_config_one[LOOP0_MANTISSA_LSB +: GAIN_FIELD_WIDTH];
         loop_gain_exponent =
            agc_config_one[LOOP0_EXPONENT_LSB +: GAIN_FIELD_WIDTH];
      end
   end

   // Error in threshold units; one extra bit, so differences below -8192 wrap
   // Converter gain is folded into the threshold by the host, not here
   assign next_gain_error =
      $signed({agc_config_one[AGC_THRESHOLD_LSB + AGC_THRESHOLD_WIDTH - 1],
               agc_config_one[AGC_THRESHOLD_LSB +: AGC_THRESHOLD_WIDTH]})
      - $signed({1'b0, agc_magnitude});

   // Mantissa as value/16: product keeps 4 extra fraction bits
   assign scaled_error =
      GAIN_STEP_WIDTH'(next_gain_error * $signed({1'b0, loop_gain_mantissa}));
   assign gain_shift   = EXPONENT_BASE - {1'b0, loop_gain_exponent};

   // Step in units of 1.5 dB, 4 fraction bits; arithmetic shift keeps sign
   // Step only; the accumulator and its limits sit outside this block
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         agc_gain_error <= '0;
         agc_gain_step  <= '0;
         agc_step_valid <= 1'b0;
      end
      else
      begin
         agc_step_valid <= agc_sample_valid;
         if (agc_sample_valid)
         begin
            agc_gain_error <= next_gain_error;
            agc_gain_step  <= scaled_error >>> gain_shift;
         end
      end
   end
endmodule

// [tb/hfac_config_properties.sv]
// Checker for the filter chain and AGC configuration block.
// Sees only the top module's ports; bound in at the foot of this file.
`timescale 1ns/10ps
module hfac_config_properties
   import hfac_pkg::*;
(
   input wire logic                                     pclk,
   input wire logic                                     presetn,
   input wire logic                                     psel,
   input wire logic                                     penable,
   input wire logic                                     pwrite,
   input wire logic [hfac_pkg::ADDR_WIDTH-1:0]          paddr,
   input wire logic [31:0]                              pwdata,
   input wire logic [3:0]                               pstrb,
   input wire logic                                     filter_align_sync_in,
   input wire logic                                     agc_sample_valid,
   input wire logic [hfac_pkg::AGC_THRESHOLD_WIDTH-1:0] agc_magnitude,
   input wire logic [hfac_pkg::HALFBAND_STAGES-1:0]     halfband_stage_enable,
   input wire logic                                     halfband_bypass,
   input wire logic [4:0]                               fir_decimation,
   input wire logic                                     fir_dual_real,
   input wire logic                                     fir_symmetry_parity,
   input wire logic                                     fir_asymmetric,
   input wire logic [hfac_pkg::FIR_TAPS_WIDTH-1:0]      fir_tap_count,
   input wire logic                                     filter_sequence_reset,
   input wire logic                                     agc_accumulator_load,
   input wire logic signed [hfac_pkg::GAIN_ERROR_WIDTH-1:0] agc_gain_error,
   input wire logic                                     agc_step_valid
);
   // ==================================================================
   // Shadow of the words; full-word writes only, so the bench's one byte-lane write is not tracked
   logic        wr_chain;
   logic        wr_agc;
   logic        sync_en;
   logic [31:0] agc_q;

   assign wr_chain = psel && penable && pwrite && pstrb == 4'hF
                     && paddr == FILTER_CHAIN_CONFIG_ADDR;
   assign wr_agc   = psel && penable && pwrite && pstrb == 4'hF
                     && paddr == AGC_CONFIG_ONE_ADDR;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync_en <= 1'b0;
         agc_q   <= 32'h0000_0000;
      end
      else
      begin
         if (wr_chain)
            sync_en <= pwdata[21];
         if (wr_agc)
            agc_q <= pwdata;
      end
   end

   // ==================================================================
   // Properties
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_bypass;
      wr_chain |-> ##2 halfband_bypass == $past(pwdata[20], 2);
   endproperty
   property p_stages;
      wr_chain |-> ##2 halfband_stage_enable ==
         ($past(pwdata[20], 2) ? 5'h00 : $past(pwdata[19:15], 2));
   endproperty
   property p_decim;
      wr_chain |-> ##2 fir_decimation ==
         {$past(pwdata[14:11], 2) == 4'h0, $past(pwdata[14:11], 2)};
   endproperty
   property p_fir;
      wr_chain |-> ##2 {fir_dual_real, fir_symmetry_parity, fir_asymmetric, fir_tap_count}
         == $past(pwdata[10:0], 2);
   endproperty
   property p_seq_reset;
      $past(filter_align_sync_in) && sync_en |=> filter_sequence_reset;
   endproperty
   property p_seq_quiet;
      !($past(filter_align_sync_in) && sync_en) |=> !filter_sequence_reset;
   endproperty
   property p_acc_load;
      $past(filter_align_sync_in) |=> agc_accumulator_load == $past(agc_q[29]);
   endproperty
   property p_gain_error;
      agc_sample_valid |=> agc_step_valid && agc_gain_error ==
         $signed({$past(agc_q[28]), $past(agc_q[28:16])})
         - $signed({1'b0, $past(agc_magnitude)});
   endproperty
   property p_step_quiet;
      !agc_sample_valid |=> !agc_step_valid;
   endproperty

   a_bypass:
      assert property (p_bypass) else $error("bypass flag wrong");
   a_stages:
      assert property (p_stages) else $error("stage enables wrong");
   a_decim:
      assert property (p_decim) else $error("decimation wrong");
   a_fir:
      assert property (p_fir) else $error("filter mode fields wrong");
   a_seq_reset:
      assert property (p_seq_reset) else $error("sequence reset missing");
   a_seq_quiet:
      assert property (p_seq_quiet) else $error("sequence reset unexpected");
   a_acc_load:
      assert property (p_acc_load) else $error("accumulator load wrong");
   a_gain_error:
      assert property (p_gain_error) else $error("gain error wrong");
   a_step_quiet:
      assert property (p_step_quiet) else $error("step valid unexpected");

   c_seq: cover property (filter_sequence_reset);
   c_load: cover property (agc_accumulator_load);
   c_step: cover property (agc_step_valid);
endmodule

bind hfac_config hfac_config_properties chk_u (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pstrb, .filter_align_sync_in, .agc_sample_valid, .agc_magnitude,
   .halfband_stage_enable, .halfband_bypass, .fir_decimation, .fir_dual_real,
   .fir_symmetry_parity, .fir_asymmetric, .fir_tap_count, .filter_sequence_reset,
   .agc_accumulator_load, .agc_gain_error, .agc_step_valid);

// [tb/hfac_apb_host.sv]
// Host model: a microprocessor issuing APB transfers to the configuration port.
// Assumes pclk from the bench; one transfer at a time with an idle cycle between.
`timescale 1ns/10ps
module hfac_apb_host
(
   input  wire logic        pclk,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   input  wire logic        pslverr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   output logic [3:0]       pstrb
);
   // ==================================================================
   // Idle bus at time zero
   initial
   begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0000_0000;
      pstrb   = 4'h0;
   end

   // Setup, then access held until pready; no fixed wait assumed
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // Scramble released lines so stale values are never relied on
      paddr   <= ~a;
      pwdata  <= ~d;
   endtask
endmodule

// [tb/halfband_fir_agc_config_test.sv]
// Self-checking bench for the filter chain and AGC configuration block.
// Registers go through the host model; sync and sample pins are driven here.
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin num_errors++; \
   $display("FAIL %s expected %0h seen %0h", nm, exp, got); end end
module halfband_fir_agc_config_test;
   import hfac_pkg::*;
   logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]         paddr, fir_tap_count;
   logic [31:0]        pwdata, prdata, rd, w, x;
   logic [3:0]         pstrb;
   logic [4:0]         halfband_stage_enable, fir_decimation;
   logic               halfband_bypass, fir_dual_real, fir_symmetry_parity, fir_asymmetric;
   logic               config_invalid, filter_sequence_reset, agc_accumulator_load;
   logic               filter_align_sync_in, agc_gain_select_in, agc_sample_valid;
   logic               agc_step_valid, err, g;
   logic [12:0]        agc_magnitude, m;
   logic signed [13:0] agc_gain_error;
   logic signed [17:0] agc_gain_step;
   logic [22:0]        dec_bus;
   logic [31:0]        corner [4] = '{32'hFFFF_FFFF, 32'h0000_0101, 32'h0008_7E00, 32'h0000_8801};
   int                 num_errors = 0;
   int                 cmp_count = 0;
   int                 cycles = 0;

   hfac_config dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .prdata, .pready, .pslverr, .filter_align_sync_in, .agc_gain_select_in,
      .agc_sample_valid, .agc_magnitude, .halfband_stage_enable, .halfband_bypass,
      .fir_decimation, .fir_dual_real, .fir_symmetry_parity, .fir_asymmetric, .fir_tap_count,
      .config_invalid, .filter_sequence_reset, .agc_accumulator_load, .agc_gain_error,
      .agc_gain_step, .agc_step_valid);
   hfac_apb_host host_u (.pclk, .pready, .prdata, .pslverr, .psel, .penable, .pwrite,
      .paddr, .pwdata, .pstrb);

   assign dec_bus = {halfband_stage_enable, halfband_bypass, fir_decimation, fir_dual_real,
                     fir_symmetry_parity, fir_asymmetric, fir_tap_count, config_invalid};

   // ==================================================================
   // Expected decode of the filter chain word
   function automatic logic [22:0] exp_chain(input logic [31:0] d);
      logic [4:0] dec;
      dec = (d[14:11] == 4'h0) ? 5'h10 : {1'b0, d[14:11]};
      return {d[20] ? 5'h00 : d[19:15], d[20], dec, d[10:0],
              d[7:0] == 8'h00 || (!d[20] && d[19:15] == 5'h00)};
   endfunction

   // Expected gain error and step; loop fields picked by gain select
   function automatic logic [31:0] exp_agc(input logic [31:0] a, input logic gs,
                                           input logic [12:0] mg);
      logic signed [13:0] e;
      logic signed [17:0] p;
      logic [7:0]         f;
      f = gs ? a[15:8] : a[7:0];
      e = $signed({a[28], a[28:16]}) - $signed({1'b0, mg});
      p = (e * $signed({1'b0, f[7:4]})) >>> (4'hF - f[3:0]);
      return {e, p};
   endfunction

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host_u.xfer(1'b1, a, d, 4'hF, rd, err);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      host_u.xfer(1'b0, a, 32'h0000_0000, 4'hF, rd, err);
      `CHK("readback", e, rd)
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // ==================================================================
   // Clock and hang guard
   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   always @(posedge pclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         num_errors++;
         end_of_test();
      end
   end

   // ==================================================================
   // Main sequence
   initial
   begin
      presetn = 1'b0;
      filter_align_sync_in = 1'b0;
      agc_gain_select_in = 1'b0;
      agc_sample_valid = 1'b0;
      agc_magnitude = 13'h0000;
      void'($urandom(79029));
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      `CHK("decode at reset", exp_chain(FILTER_CHAIN_RESET), dec_bus)
      rd_chk(FILTER_CHAIN_CONFIG_ADDR, FILTER_CHAIN_RESET);
      rd_chk(AGC_CONFIG_ONE_ADDR, AGC_CONFIG_RESET);
      // Corner words first, including deliberately illegal ones, then random legal words
      for (int i = 0; i < 24; i++)
      begin
         w = (i < 4) ? corner[i] : $urandom;
         if (i >= 4 && w[7:0] == 8'h00) w[0] = 1'b1;
         if (i >= 4 && !w[20] && w[19:15] == 5'h00) w[15] = 1'b1;
         wr(FILTER_CHAIN_CONFIG_ADDR, w);
         repeat (2) @(negedge pclk);
         x = {9'h000, exp_chain(w)};
         `CHK("cascade", x[22:12], dec_bus[22:12])
         `CHK("fir", x[11:0], dec_bus[11:0])
         rd_chk(FILTER_CHAIN_CONFIG_ADDR, w & FILTER_CHAIN_MASK);
      end
      host_u.xfer(1'b0, 8'h10, 32'h0000_0000, 4'hF, rd, err);
      `CHK("unmapped error", 1'b1, err)
      `CHK("unmapped data", 32'h0000_0000, rd)
      // Sync pulse with both enables off, then on
      for (int en = 0; en < 2; en++)
      begin
         wr(FILTER_CHAIN_CONFIG_ADDR, {10'h000, en[0], 21'h10_0001});
         wr(AGC_CONFIG_ONE_ADDR, {2'b00, en[0], 29'h0000_0000});
         @(posedge pclk);
         filter_align_sync_in <= 1'b1;
         @(posedge pclk);
         filter_align_sync_in <= 1'b0;
         @(posedge pclk);
         @(negedge pclk);
         `CHK("sequence reset", en[0], filter_sequence_reset)
         `CHK("accumulator load", en[0], agc_accumulator_load)
      end
      // Sync was seen; the status bit holds until a clearing write
      rd_chk(CONFIG_STATUS_ADDR, 32'h0000_0004);
      wr(CONFIG_STATUS_ADDR, 32'h0000_0004);
      rd_chk(CONFIG_STATUS_ADDR, 32'h0000_0000);
      // Threshold drawn raw: the host is assumed to fold in the converter gain
      for (int i = 0; i < 24; i++)
      begin
         w = (i == 0) ? 32'h1000_FF0F : ($urandom & AGC_CONFIG_MASK);
         g = $urandom;
         m = $urandom % 2048;
         wr(AGC_CONFIG_ONE_ADDR, w);
         agc_gain_select_in <= g;
         agc_sample_valid <= 1'b1;
         agc_magnitude <= m;
         @(posedge pclk);
         agc_sample_valid <= 1'b0;
         @(negedge pclk);
         x = exp_agc(w, g, m);
         `CHK("gain error", x[31:18], agc_gain_error)
         `CHK("step", x[17:0], agc_gain_step)
         `CHK("step valid", 1'b1, agc_step_valid)
         rd_chk(AGC_CONFIG_ONE_ADDR, w);
      end
      // Byte-lane write: only the loop-one fields may change
      host_u.xfer(1'b1, AGC_CONFIG_ONE_ADDR, 32'hFFFF_FFFF, 4'h2, rd, err);
      rd_chk(AGC_CONFIG_ONE_ADDR, w | 32'h0000_FF00);
      end_of_test();
   end
endmodule
